// file: hw/fpec_pkg.sv
// Package with register map, field positions, reset values and timing for the flash controller.
package fpec_pkg;
    // Register byte offsets from the controller base.
    localparam logic [7:0] FPEC_OFF_MODE  = 8'h04;
    localparam logic [7:0] FPEC_OFF_CTRL  = 8'h08;
    localparam logic [7:0] FPEC_OFF_ADDR  = 8'h0c;
    localparam logic [7:0] FPEC_OFF_DATA  = 8'h10;
    localparam logic [7:0] FPEC_OFF_TMR   = 8'h14;
    localparam logic [7:0] FPEC_OFF_TICK  = 8'h1c;
    localparam logic [7:0] FPEC_OFF_CRC   = 8'h20;
    localparam logic [7:0] FPEC_OFF_CFG   = 8'h30;
    localparam logic [7:0] FPEC_OFF_HWID  = 8'h40;
    localparam logic [7:0] FPEC_OFF_BOOT  = 8'h74;
    localparam logic [7:0] FPEC_OFF_WPROT = 8'h78;
    localparam logic [7:0] FPEC_OFF_RPROT = 8'h7c;
    localparam logic [31:0] FPEC_BASE     = 32'h4000_0100;
    localparam logic [23:0] FPEC_BASE_HI  = 24'h4000_01;

    // Reset values.
    localparam logic [31:0] FPEC_RST_MODE  = 32'h0100_0000;
    localparam logic [31:0] FPEC_RST_CTRL  = 32'h0500_0000;
    localparam logic [31:0] FPEC_RST_TMR   = 32'h0001_8fff;
    localparam logic [31:0] FPEC_RST_CFG   = 32'h0000_8200;
    localparam logic [31:0] FPEC_RST_WPROT = 32'h00ff_ff00;
    localparam logic [31:0] FPEC_RST_RPROT = 32'h0000_00ff;
    // Identity value is arbitrary.
    localparam logic [31:0] FPEC_HWID_VAL  = 32'h1234_0000;

    // Mode register fields.
    localparam int FPEC_MODE_IDLE   = 24;
    localparam int FPEC_MODE_TRMEN  = 17;
    localparam int FPEC_MODE_TRM    = 16;
    localparam int FPEC_MODE_FEMOD  = 9;
    localparam int FPEC_MODE_FMOD   = 8;
    localparam logic [7:0] FPEC_KEY_A5 = 8'ha5;
    localparam logic [7:0] FPEC_KEY_5A = 8'h5a;
    localparam logic [7:0] FPEC_KEY_81 = 8'h81;
    localparam logic [7:0] FPEC_KEY_28 = 8'h28;

    // Control register fields.
    localparam int FPEC_CTRL_ERS   = 1;
    localparam int FPEC_CTRL_PGM   = 2;
    localparam int FPEC_CTRL_PAGE_BUFFER_LOAD  = 3;
    localparam int FPEC_CTRL_WE    = 4;
    localparam int FPEC_CTRL_AEF   = 8;
    localparam int FPEC_CTRL_TMREN = 20;
    localparam int FPEC_CTRL_MODE_HI = 17;
    localparam int FPEC_CTRL_OTP_LO  = 28;
    localparam logic [31:0] FPEC_CTRL_MODE_MASK = 32'h0003_ffff;
    localparam logic [31:0] FPEC_CTRL_TRIM_MASK = 32'hf000_0000;

    // Configuration fields.
    localparam int FPEC_CFG_WAIT_LO = 8;
    localparam int FPEC_CFG_CRCINIT = 7;
    localparam int FPEC_CFG_CRCEN   = 6;
    localparam logic [1:0] FPEC_WAIT_PREFETCH = 2'h3;

    // Array geometry.
    localparam int FPEC_UNIT_WORDS   = 32;
    localparam int FPEC_OTP_WORDS    = 32;
    localparam int FPEC_SECTORS      = 16;
    localparam int FPEC_SECTOR_SHIFT = 12;
    localparam int FPEC_PAGES        = 512;
    localparam int FPEC_PAGE_BYTES   = 128;
    localparam logic [31:0] FPEC_PROT_PATTERN = 32'ha5a5_a5a5;
    localparam logic [15:0] FPEC_CRC_POLY     = 16'h1021;

    // Clocks: timing oscillator and bus clock.
    localparam int FPEC_OSC_MHZ  = 40;
    localparam int FPEC_CLK_MHZ  = 40;
    localparam int FPEC_ZW_MHZ   = 20;
    localparam int FPEC_OSC_DIV  = (FPEC_CLK_MHZ + FPEC_OSC_MHZ - 1) / FPEC_OSC_MHZ;

    typedef enum logic [1:0] {FPEC_S_IDLE, FPEC_S_RUN, FPEC_S_DONE} fpec_state_type;
    typedef enum logic [1:0] {FPEC_R_IDLE, FPEC_R_WAIT, FPEC_R_DATA} fpec_rd_type;
endpackage

// file: hw/fpec_ctrl.sv
// Flash program/erase sequencer with AHB-Lite register slave and array read port.
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
module fpec_ctrl #(
    parameter int AW = 14
) (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    input  wire logic                  fr_req,
    input  wire logic [31:0]           fr_addr,
    input  wire logic                  fr_untrusted,
    output logic                       fr_valid,
    output logic [31:0]                fr_data,
    input  wire logic [31:0]           arr_rdata,
    output logic [AW-1:0]              arr_addr,
    output logic [31:0]                arr_wdata,
    output logic                       arr_pgm,
    output logic                       arr_ers,
    output logic                       arr_bulk,
    output logic                       arr_otp,
    output logic                       arr_page_buffer_load,
    output logic                       arr_rd
);
    import fpec_pkg::*;

    typedef struct packed {
        logic            dp_wr;
        logic [7:0]      dp_off;
        logic            dp_hit;
        logic [31:0]     rdata;
        logic [31:0]     mode;
        logic [31:0]     ctrl;
        logic [31:0]     addr;
        logic [31:0]     data;
        logic [31:0]     tmr;
        logic [31:0]     tick;
        logic [15:0]     crc;
        logic [31:0]     cfg;
        logic [31:0]     boot;
        logic [31:0]     wprot;
        logic [31:0]     rprot;
        logic [7:0]      key;
        fpec_state_type  st;
        logic [17:0]     cnt;
        logic [4:0]      word;
        logic [AW-1:0]   a_addr;
        logic [31:0]     a_wdata;
        logic            a_pgm;
        logic            a_ers;
        logic            a_bulk;
        logic            a_otp;
        logic            a_page_buffer_load;
        fpec_rd_type     rst_st;
        logic [1:0]      rwait;
        logic            a_rd;
        logic            f_valid;
        logic [31:0]     f_data;
        logic [31:0]     f_addr;
        logic [31:0]     pf_addr;
        logic [31:0]     pf_data;
        logic            pf_ok;
        logic            pf_busy;
        logic            untrust;
    } fpec_regs_type;

    fpec_regs_type s_r;
    fpec_regs_type s_nxt;

    logic [15:0] crc_next;
    logic        sec_prot;
    logic        mode_on;
    logic        trim_on;
    logic        addr_ok;
    logic        prot_rd;
    logic [31:0] rd_word;

    ////////////////////////////////////////////////////////////////////////////
    // CRC16 over the raw array word of each read answered in FPEC_R_DATA, one bit per loop step.
    always_comb begin
        crc_next = s_r.crc;
        for (int i = 31; i >= 0; i--) begin
            if (crc_next[15] ^ arr_rdata[i]) begin
                crc_next = {crc_next[14:0], 1'b0} ^ FPEC_CRC_POLY;
            end else begin
                crc_next = {crc_next[14:0], 1'b0};
            end
        end
    end

    // Combinational helpers for decode, protection and mode checks.
    always_comb begin
        mode_on  = s_r.mode[FPEC_MODE_FMOD] | s_r.mode[FPEC_MODE_FEMOD];
        trim_on  = s_r.mode[FPEC_MODE_TRM];
        sec_prot = s_r.wprot[s_r.addr[FPEC_SECTOR_SHIFT +: 4]];
        addr_ok  = (haddr[31:8] == FPEC_BASE_HI);
        prot_rd  = (s_r.rprot[7:0] != FPEC_RST_RPROT[7:0]) & s_r.untrust;
        rd_word  = prot_rd ? FPEC_PROT_PATTERN : arr_rdata;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic for the bus slave, sequencer and read path.
    always_comb begin
        s_nxt = s_r;
        s_nxt.dp_wr = 1'b0;
        s_nxt.dp_hit = 1'b0;
        s_nxt.a_page_buffer_load = 1'b0;
        s_nxt.f_valid = 1'b0;
        s_nxt.a_rd = 1'b0;

        // Data phase of a write: apply per register with access gating.
        if (s_r.dp_wr && s_r.dp_hit) begin
            case (s_r.dp_off)
                FPEC_OFF_MODE: begin
                    // Key sequence: two key writes open mode or trim entry.
                    s_nxt.key = hwdata[7:0];
                    if (s_r.key == FPEC_KEY_A5 && hwdata[7:0] == FPEC_KEY_5A) begin
                        s_nxt.mode[FPEC_MODE_FMOD] = 1'b1;
                    end else if (s_r.key == FPEC_KEY_81 && hwdata[7:0] == FPEC_KEY_28) begin
                        s_nxt.mode[FPEC_MODE_TRM] = 1'b1;
                        s_nxt.mode[FPEC_MODE_TRMEN] = 1'b1;
                    end else if (hwdata[7:0] == 8'h00) begin
                        s_nxt.mode[FPEC_MODE_FMOD] = 1'b0;
                        s_nxt.mode[FPEC_MODE_TRM] = 1'b0;
                        s_nxt.mode[FPEC_MODE_TRMEN] = 1'b0;
                    end
                    s_nxt.mode[7:0] = hwdata[7:0];
                end
                FPEC_OFF_CTRL: begin
                    if (mode_on) begin
                        s_nxt.ctrl = (s_r.ctrl & ~FPEC_CTRL_MODE_MASK) |
                                     (hwdata & FPEC_CTRL_MODE_MASK);
                    end
                    if (trim_on) begin
                        s_nxt.ctrl = (s_nxt.ctrl & ~FPEC_CTRL_TRIM_MASK) |
                                     (hwdata & FPEC_CTRL_TRIM_MASK);
                    end
                    s_nxt.ctrl[FPEC_CTRL_TMREN] = hwdata[FPEC_CTRL_TMREN];
                end
                FPEC_OFF_ADDR:  s_nxt.addr  = hwdata;
                FPEC_OFF_DATA:  s_nxt.data  = hwdata;
                FPEC_OFF_TMR:   s_nxt.tmr   = hwdata;
                FPEC_OFF_CFG:   s_nxt.cfg   = hwdata;
                FPEC_OFF_BOOT:  s_nxt.boot  = hwdata;
                FPEC_OFF_WPROT: s_nxt.wprot = hwdata;
                FPEC_OFF_RPROT: s_nxt.rprot = hwdata;
                default: begin
                    s_nxt.key = s_r.key;
                end
            endcase
        end

        // Read data for the next data phase.
        if (htrans[1] && hsel && hready && !hwrite) begin
            case (haddr[7:0])
                FPEC_OFF_MODE:  s_nxt.rdata = s_r.mode;
                FPEC_OFF_CTRL:  s_nxt.rdata = s_r.ctrl;
                FPEC_OFF_ADDR:  s_nxt.rdata = s_r.addr;
                FPEC_OFF_DATA:  s_nxt.rdata = s_r.data;
                FPEC_OFF_TMR:   s_nxt.rdata = s_r.tmr;
                FPEC_OFF_TICK:  s_nxt.rdata = s_r.tick;
                FPEC_OFF_CRC:   s_nxt.rdata = {16'h0000, s_r.crc};
                FPEC_OFF_CFG:   s_nxt.rdata = s_r.cfg;
                FPEC_OFF_HWID:  s_nxt.rdata = FPEC_HWID_VAL;
                FPEC_OFF_BOOT:  s_nxt.rdata = s_r.boot;
                FPEC_OFF_WPROT: s_nxt.rdata = s_r.wprot;
                FPEC_OFF_RPROT: s_nxt.rdata = s_r.rprot;
                default:        s_nxt.rdata = 32'h0000_0000;
            endcase
            if (!addr_ok) begin
                s_nxt.rdata = 32'h0000_0000;
            end
        end
        if (htrans[1] && hsel && hready) begin
            s_nxt.dp_wr  = hwrite;
            s_nxt.dp_off = haddr[7:0];
            s_nxt.dp_hit = addr_ok;
        end

        // Sequencer: page load, then timed program or erase.
        case (s_r.st)
            FPEC_S_IDLE: begin
                if (s_r.ctrl[FPEC_CTRL_PAGE_BUFFER_LOAD] && s_r.ctrl[FPEC_CTRL_WE]) begin
                    s_nxt.a_page_buffer_load  = 1'b1;
                    s_nxt.a_wdata = s_r.data;
                    // The array port takes a word index, so the byte address drops two bits.
                    s_nxt.a_addr  = s_r.addr[AW+1:2];
                    s_nxt.word    = s_r.word + 5'h01;
                    s_nxt.ctrl[FPEC_CTRL_PAGE_BUFFER_LOAD] = 1'b0;
                end
                if ((s_r.ctrl[FPEC_CTRL_PGM] || s_r.ctrl[FPEC_CTRL_ERS]) &&
                    s_r.ctrl[FPEC_CTRL_WE]) begin
                    s_nxt.ctrl[FPEC_CTRL_PGM] = 1'b0;
                    s_nxt.ctrl[FPEC_CTRL_ERS] = 1'b0;
                    if (!sec_prot || s_r.ctrl[FPEC_CTRL_AEF] ||
                        (s_r.ctrl[31:28] != 4'h0)) begin
                        // Unit address aligned to 32 words; OTP via access enables.
                        s_nxt.a_addr = {s_r.addr[AW+1:7], 5'h00};
                        s_nxt.a_pgm  = s_r.ctrl[FPEC_CTRL_PGM];
                        s_nxt.a_ers  = s_r.ctrl[FPEC_CTRL_ERS];
                        s_nxt.a_bulk = s_r.ctrl[FPEC_CTRL_AEF] &
                                       s_r.ctrl[FPEC_CTRL_ERS];
                        s_nxt.a_otp  = (s_r.ctrl[31:28] != 4'h0);
                        s_nxt.cnt    = s_r.tmr[17:0];
                        s_nxt.mode[FPEC_MODE_IDLE] = 1'b0;
                        s_nxt.st     = FPEC_S_RUN;
                    end
                end
            end
            FPEC_S_RUN: begin
                // Timer counts down one step per clock cycle.
                if (s_r.cnt == 18'h00000) begin
                    s_nxt.st = FPEC_S_DONE;
                end else begin
                    s_nxt.cnt = s_r.cnt - 18'h00001;
                end
            end
            FPEC_S_DONE: begin
                s_nxt.a_pgm  = 1'b0;
                s_nxt.a_ers  = 1'b0;
                s_nxt.a_bulk = 1'b0;
                s_nxt.a_otp  = 1'b0;
                s_nxt.word   = 5'h00;
                s_nxt.mode[FPEC_MODE_IDLE] = 1'b1;
                s_nxt.st     = FPEC_S_IDLE;
            end
            default: s_nxt.st = FPEC_S_IDLE;
        endcase
        if (s_r.ctrl[FPEC_CTRL_TMREN] && s_r.st == FPEC_S_RUN) begin
            s_nxt.tick = s_r.tick + 32'h0000_0001;
        end

        // Array read path at the requested address with wait states or prefetch.
        if (s_r.cfg[FPEC_CFG_CRCINIT]) begin
            s_nxt.crc = 16'h0000;
        end
        case (s_r.rst_st)
            FPEC_R_IDLE: begin
                // A request still high in the cycle its answer stands is the old one.
                if (fr_req && !s_r.f_valid && s_r.st == FPEC_S_IDLE) begin
                    s_nxt.f_addr  = fr_addr;
                    s_nxt.untrust = fr_untrusted;
                    if (s_r.cfg[9:8] == FPEC_WAIT_PREFETCH && s_r.pf_ok &&
                        s_r.pf_addr == fr_addr) begin
                        s_nxt.f_valid = 1'b1;
                        s_nxt.f_data  = s_r.pf_data;
                        s_nxt.pf_ok   = 1'b0;
                    end else begin
                        s_nxt.a_addr = fr_addr[AW+1:2];
                        s_nxt.a_rd   = 1'b1;
                        s_nxt.rwait  = s_r.cfg[9:8];
                        s_nxt.pf_busy = 1'b0;
                        s_nxt.rst_st = FPEC_R_WAIT;
                    end
                end else if (s_r.cfg[9:8] == FPEC_WAIT_PREFETCH && !s_r.pf_ok &&
                             s_r.st == FPEC_S_IDLE) begin
                    // Fetch next word ahead of the bus.
                    s_nxt.pf_addr = s_r.f_addr + 32'h0000_0004;
                    s_nxt.a_addr  = s_nxt.pf_addr[AW+1:2];
                    s_nxt.a_rd    = 1'b1;
                    s_nxt.rwait   = 2'h2;
                    s_nxt.pf_busy = 1'b1;
                    s_nxt.rst_st  = FPEC_R_WAIT;
                end
            end
            FPEC_R_WAIT: begin
                if (s_r.rwait == 2'h0 || s_r.rwait == 2'h3) begin
                    s_nxt.rst_st = FPEC_R_DATA;
                end else begin
                    s_nxt.rwait = s_r.rwait - 2'h1;
                end
            end
            FPEC_R_DATA: begin
                if (s_r.pf_busy) begin
                    s_nxt.pf_data = arr_rdata;
                    s_nxt.pf_ok   = 1'b1;
                end else begin
                    s_nxt.f_valid = 1'b1;
                    s_nxt.f_data  = rd_word;
                    if (s_r.cfg[FPEC_CFG_CRCEN]) begin
                        s_nxt.crc = crc_next;
                    end
                end
                s_nxt.pf_busy = 1'b0;
                s_nxt.rst_st  = FPEC_R_IDLE;
            end
            default: s_nxt.rst_st = FPEC_R_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register with reset values.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_r       <= '0;
            s_r.mode  <= FPEC_RST_MODE;
            s_r.ctrl  <= FPEC_RST_CTRL;
            s_r.tmr   <= FPEC_RST_TMR;
            s_r.cfg   <= FPEC_RST_CFG;
            s_r.wprot <= FPEC_RST_WPROT;
            s_r.rprot <= FPEC_RST_RPROT;
            s_r.st    <= FPEC_S_IDLE;
            s_r.rst_st <= FPEC_R_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register; hreadyout and hresp are tied constant.
    always_comb begin
        hreadyout = 1'b1;
        hresp     = 1'b0;
        hrdata    = s_r.rdata;
        fr_valid  = s_r.f_valid;
        fr_data   = s_r.f_data;
        arr_addr  = s_r.a_addr;
        arr_wdata = s_r.a_wdata;
        arr_pgm   = s_r.a_pgm;
        arr_ers   = s_r.a_ers;
        arr_bulk  = s_r.a_bulk;
        arr_otp   = s_r.a_otp;
        arr_page_buffer_load  = s_r.a_page_buffer_load;
        arr_rd    = s_r.a_rd;
    end
endmodule

// file: sim/fpec_flash_model.sv
// Behavioural flash array that answers the controller's array port.
`timescale 1ns/1ps
module fpec_flash_model #(
    parameter int AW = 14
) (
    input  wire logic          clk,
    input  wire logic [AW-1:0] arr_addr,
    input  wire logic [31:0]   arr_wdata,
    input  wire logic          arr_pgm,
    input  wire logic          arr_ers,
    input  wire logic          arr_page_buffer_load,
    input  wire logic          arr_rd,
    output logic      [31:0]   arr_rdata
);
    logic [31:0] mem [2**AW];
    logic [31:0] pbuf [32];
    logic        pgm_q;
    logic        ers_q;
    // Preload each word with a pattern built from its word index.
    initial begin
        for (int i = 0; i < 2**AW; i++) begin
            mem[i] = 32'h5a00_0000 | 32'(i);
        end
        foreach (pbuf[i]) pbuf[i] = 32'hffff_ffff;
        arr_rdata = 32'h0;
        pgm_q = 1'b0;
        ers_q = 1'b0;
    end
    // Read, buffer load, and commit of one 32-word unit when an operation ends.
    always @(posedge clk) begin
        pgm_q <= arr_pgm;
        ers_q <= arr_ers;
        if (arr_rd) arr_rdata <= mem[arr_addr];
        if (arr_page_buffer_load) pbuf[arr_addr[4:0]] <= arr_wdata;
        for (int i = 0; i < 32; i++) begin
            if (pgm_q && !arr_pgm) begin
                mem[{arr_addr[AW-1:5], 5'(i)}] <= mem[{arr_addr[AW-1:5], 5'(i)}] & pbuf[i];
                pbuf[i] <= 32'hffff_ffff;
            end
            if (ers_q && !arr_ers) mem[{arr_addr[AW-1:5], 5'(i)}] <= 32'hffff_ffff;
        end
    end
endmodule

// file: sim/fpec_ctrl_chk.sv
// Port-level assertions for the flash controller.
`timescale 1ns/1ps
module fpec_ctrl_chk #(
    parameter int AW = 14
) (
    input wire logic          clk,
    input wire logic          sys_rst,
    input wire logic          hreadyout,
    input wire logic          hresp,
    input wire logic          fr_req,
    input wire logic          fr_valid,
    input wire logic [AW-1:0] arr_addr,
    input wire logic          arr_pgm,
    input wire logic          arr_ers,
    input wire logic          arr_page_buffer_load,
    input wire logic          arr_rd
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////
    a_bus_okay: assert property (
        hreadyout && !hresp) else $error("Bus slave not ready or not okay.");
    a_page_buffer_load_pulse: assert property (
        arr_page_buffer_load |=> !arr_page_buffer_load) else $error("Buffer load strobe too long.");
    a_op_exclusive: assert property (
        !(arr_pgm && arr_ers)) else $error("Program and erase at once.");
    a_op_holds: assert property (
        $rose(arr_pgm) |=> arr_pgm [*8]) else $error("Program cut short.");
    a_unit_align: assert property (
        ($rose(arr_pgm) || $rose(arr_ers)) |-> arr_addr[4:0] == 5'h0)
        else $error("Operation not on a 32-word unit.");
    a_no_rd_in_op: assert property (
        (arr_pgm || arr_ers) |-> !arr_rd) else $error("Array read during operation.");
    a_read_answer: assert property (
        $rose(fr_req) |-> ##[1:8] fr_valid) else $error("Flash read not answered.");
    a_valid_pulse: assert property (
        fr_valid |=> !fr_valid) else $error("Read valid longer than a cycle.");
endmodule
bind fpec_ctrl fpec_ctrl_chk #(.AW(AW)) u_chk (.clk, .sys_rst, .hreadyout, .hresp, .fr_req,
    .fr_valid, .arr_addr, .arr_pgm, .arr_ers, .arr_page_buffer_load, .arr_rd);

// file: sim/flash_program_erase_ctrl_tb.sv
// Self-checking bench for the flash program/erase controller.
`timescale 1ns/1ps
module flash_program_erase_ctrl_tb;
    import fpec_pkg::*;
    typedef struct packed {
        logic        wr;
        logic [7:0]  off;
        logic [31:0] wd;
        logic [31:0] exp;
    } fpec_row_type;
    localparam fpec_row_type ROWS [15] = '{
        '{1'b0, FPEC_OFF_MODE, 32'h0, FPEC_RST_MODE}, '{1'b0, FPEC_OFF_CTRL, 32'h0, FPEC_RST_CTRL},
        '{1'b0, FPEC_OFF_ADDR, 32'h0, 32'h0}, '{1'b0, FPEC_OFF_DATA, 32'h0, 32'h0},
        '{1'b0, FPEC_OFF_TMR, 32'h0, FPEC_RST_TMR}, '{1'b0, FPEC_OFF_TICK, 32'h0, 32'h0},
        '{1'b0, FPEC_OFF_CRC, 32'h0, 32'h0}, '{1'b0, FPEC_OFF_CFG, 32'h0, FPEC_RST_CFG},
        '{1'b0, FPEC_OFF_WPROT, 32'h0, FPEC_RST_WPROT}, '{1'b0, FPEC_OFF_HWID, 32'h0, FPEC_HWID_VAL},
        '{1'b0, FPEC_OFF_RPROT, 32'h0, FPEC_RST_RPROT}, '{1'b1, FPEC_OFF_CRC, 32'hffff, 32'h0},
        '{1'b1, 8'h18, 32'h55, 32'h0}, '{1'b1, FPEC_OFF_ADDR, 32'h200, 32'h200},
        '{1'b1, FPEC_OFF_DATA, 32'h5a5a_0f0f, 32'h5a5a_0f0f}};
    logic        clk, sys_rst, hsel, hwrite, hreadyout, hresp, fr_req, fr_untrusted, fr_valid;
    logic [31:0] haddr, hwdata, hrdata, fr_addr, fr_data, arr_rdata, arr_wdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [13:0] arr_addr;
    logic        arr_pgm, arr_ers, arr_bulk, arr_otp, arr_page_buffer_load, arr_rd;
    int          err_count, total_checks, cyc, lat, n;
    fpec_ctrl #(.AW(14)) uut (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .fr_req, .fr_addr, .fr_untrusted,
        .fr_valid, .fr_data, .arr_rdata, .arr_addr, .arr_wdata, .arr_pgm, .arr_ers, .arr_bulk,
        .arr_otp, .arr_page_buffer_load, .arr_rd);
    fpec_flash_model #(.AW(14)) u_arr (.clk, .arr_addr, .arr_wdata, .arr_pgm, .arr_ers,
        .arr_page_buffer_load, .arr_rd, .arr_rdata);
    ////////////////////////////////////////////////////////////////////////////
    // Clock of 25 ns.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Cuts a hang short.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Counts a comparison and reports a mismatch.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One single-word transfer; the answer is taken at the second ready edge.
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wreg(input logic [7:0] off, input logic [31:0] d);
        bus(1'b1, FPEC_BASE | {24'h0, off}, d);
    endtask
    task automatic rreg(input logic [7:0] off);
        bus(1'b0, FPEC_BASE | {24'h0, off}, 32'h0);
    endtask
    // Holds the read request until valid, counting the edges it took.
    task automatic fread(input logic [31:0] a, input logic u);
        fr_addr <= a;
        fr_untrusted <= u;
        fr_req <= 1'b1;
        lat = 0;
        do begin
            @(posedge clk);
            lat++;
        end while (fr_valid !== 1'b1 && lat < 50);
        rd = fr_data;
        fr_req <= 1'b0;
        @(posedge clk);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        {sys_rst, hsel, hwrite, fr_req, fr_untrusted} = 5'b10000;
        {haddr, hwdata, fr_addr} = '0;
        htrans = 2'h0;
        hsize = 3'h2;
        {err_count, total_checks, cyc} = '0;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        foreach (ROWS[i]) begin
            if (ROWS[i].wr) wreg(ROWS[i].off, ROWS[i].wd);
            rreg(ROWS[i].off);
            check(rd, ROWS[i].exp);
        end
        bus(1'b0, 32'h4000_0008, 32'h0);
        check(rd, 32'h0);
        $display("register table done");
        wreg(FPEC_OFF_CTRL, 32'h10);
        rreg(FPEC_OFF_CTRL);
        check(rd & FPEC_CTRL_MODE_MASK, 32'h0);
        wreg(FPEC_OFF_MODE, {24'h0, FPEC_KEY_A5});
        wreg(FPEC_OFF_MODE, {24'h0, FPEC_KEY_5A});
        wreg(FPEC_OFF_CTRL, 32'hf000_0010);
        rreg(FPEC_OFF_CTRL);
        check(rd & (FPEC_CTRL_MODE_MASK | FPEC_CTRL_TRIM_MASK), 32'h10);
        $display("control gating done");
        wreg(FPEC_OFF_TMR, 32'd20);
        wreg(FPEC_OFF_CTRL, 32'h18);
        wreg(FPEC_OFF_CTRL, 32'h14);
        @(posedge clk);
        rreg(FPEC_OFF_MODE);
        check(rd & 32'h0100_0000, 32'h0);
        n = 0;
        do begin
            rreg(FPEC_OFF_MODE);
            n++;
        end while (rd[24] !== 1'b1 && n < 100);
        check({31'h0, n inside {[8:16]}}, 32'h1);
        fread(32'h200, 1'b0);
        check(rd, 32'h5a5a_0f0f & 32'h5a00_0080);
        $display("program done");
        wreg(FPEC_OFF_ADDR, 32'h8000);
        wreg(FPEC_OFF_CTRL, 32'h14);
        rreg(FPEC_OFF_MODE);
        check(rd & 32'h0100_0000, 32'h0100_0000);
        fread(32'h8000, 1'b0);
        check(rd, 32'h5a00_2000);
        $display("protected sector done");
        wreg(FPEC_OFF_RPROT, 32'h39);
        fread(32'h200, 1'b1);
        check(rd, FPEC_PROT_PATTERN);
        fread(32'h200, 1'b0);
        check(rd, 32'h5a5a_0f0f & 32'h5a00_0080);
        wreg(FPEC_OFF_RPROT, 32'hff);
        $display("read protection done");
        for (int w = 0; w < 4; w++) begin
            wreg(FPEC_OFF_CFG, 32'h8000 | (32'(w) << 8));
            fread(32'h40 + 32'(4 * w), 1'b0);
            check(rd, 32'h5a00_0010 + 32'(w));
            if (w < 3) check({31'h0, lat inside {[w + 2:w + 5]}}, 32'h1);
        end
        $display("wait states done");
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rreg(FPEC_OFF_TMR);
        check(rd, FPEC_RST_TMR);
        rreg(FPEC_OFF_MODE);
        check(rd, FPEC_RST_MODE);
        $display("second reset done");
        give_verdict();
    end
endmodule
